// ---- common/curve_pkg.sv ----
package curve_pkg;
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_ALARM_HI = 12'h004;
  localparam logic [11:0] OFS_ALARM_LO = 12'h008;
  localparam logic [11:0] OFS_DEADBAND = 12'h00c;
  localparam logic [11:0] OFS_STATUS = 12'h010;
  localparam logic [11:0] OFS_TEMP = 12'h014;
  localparam logic [11:0] OFS_OUTPUT = 12'h018;
  localparam logic [11:0] OFS_CURVE_SEL = 12'h01c;
  localparam logic [11:0] OFS_HDR = 12'h020;
  localparam logic [11:0] OFS_LIMIT = 12'h024;
  localparam logic [11:0] OFS_PT_IDX = 12'h028;
  localparam logic [11:0] OFS_PT_SENS = 12'h02c;
  localparam logic [11:0] OFS_PT_KELV = 12'h030;
  localparam logic [11:0] OFS_CMD = 12'h034;
  localparam logic [11:0] OFS_NAME = 12'h100;
  localparam logic [11:0] OFS_SERIAL = 12'h140;
  // Control word fields
  localparam int CTRL_W = 19;
  localparam int MODE_BIT = 0;
  localparam int RANGE_LSB = 1;
  localparam int BRIGHT_LSB = 4;
  localparam int ALARM_ON_BIT = 13;
  localparam int LATCH_BIT = 14;
  localparam int RLY1_LSB = 15;
  localparam int RLY2_LSB = 17;
  // Voltage mode, range 5, brightness 8, diode input, kelvin, all else off
  localparam logic [CTRL_W-1:0] CTRL_DEFAULT = 19'h0008a;
  localparam logic [2:0] RANGE_MAX = 3'h5;
  localparam logic [1:0] RLY_ON = 2'h1;
  localparam logic [1:0] RLY_ALARM = 2'h2;
  // Curve storage
  localparam logic [4:0] USER_CURVE = 5'h15;
  localparam logic [4:0] DEFAULT_CURVE = 5'h01;
  localparam int MAX_PTS = 200;
  localparam int NAME_LEN = 15;
  localparam int SERIAL_LEN = 10;
  localparam logic [15:0] LIMIT_DEFAULT = 16'h0177;
  localparam logic [1:0] FMT_VOLT = 2'h0;
  localparam logic [1:0] FMT_LOGOHM = 2'h2;
  // Kelvin held in units of 0.0001 K
  localparam logic [31:0] K_SPAN = 32'h00e4e1c0;
  localparam logic [31:0] K_FINE_TOP = 32'h000186a0;
  localparam logic [31:0] K_COARSE = 32'h00989680;
  localparam logic [31:0] K_STEP_MID = 32'h0000000a;
  localparam logic [31:0] K_STEP_COARSE = 32'h00000064;
  localparam logic [31:0] ALARM_SCALE = 32'h000003e8;
  // Output scaling: millivolts, or microamps with a 4 mA floor
  localparam logic [23:0] V_FULL_MV = 24'h002710;
  localparam logic [23:0] I_SPAN_UA = 24'h003e80;
  localparam logic [15:0] I_ZERO_UA = 16'h0fa0;
  localparam int DIV_STEPS = 48;
  // Key hold time
  localparam int HOLD_S = 10;
  localparam int CLK_HZ = 10_000_000;

  typedef enum logic [2:0] {
    DISP_NORMAL = 3'b000,
    DISP_LOCKED = 3'b001,
    DISP_UNLOCKED = 3'b010,
    DISP_ALL_ON = 3'b011,
    DISP_DATE = 3'b100,
    DISP_ERROR = 3'b101
  } disp_type;

  typedef enum logic [1:0] {
    CV_IDLE = 2'b00,
    CV_SEARCH = 2'b01,
    CV_DIV_T = 2'b10,
    CV_DIV_O = 2'b11
  } conv_type;

  // Full-scale temperature of each output range, 0.0001 K units
  function automatic logic [23:0] range_top(input logic [2:0] r);
    case (r)
      3'h0: range_top = 24'h030d40;
      3'h1: range_top = 24'h0f4240;
      3'h2: range_top = 24'h1e8480;
      3'h3: range_top = 24'h3197d0;
      3'h4: range_top = 24'h487ab0;
      default: range_top = 24'h989680;
    endcase
  endfunction : range_top
endpackage : curve_pkg

// ---- rtl/curve_readout.sv ----
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
module curve_readout
  import curve_pkg::*;
#(
  parameter int HOLD_CYCLES = HOLD_S * CLK_HZ,
  parameter logic [23:0] FW_DATE = 24'h010100  // Arbitrary value
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic key_select,
  input wire logic key_enter,
  input wire logic key_up,
  input wire logic key_down,
  input wire logic [23:0] sensor_value,
  output logic out_current,
  output logic [15:0] out_level,
  output logic [2:0] disp_mode,
  output logic [23:0] disp_value,
  output logic [3:0] disp_bright,
  output logic relay1,
  output logic relay2
);
  logic [CTRL_W-1:0] ctrl_reg;
  logic [15:0] alarm_hi_reg, alarm_lo_reg, deadband_reg, limit_reg;
  logic [4:0] curve_sel_reg;
  logic [1:0] fmt_reg;
  logic [7:0] pt_idx_reg;
  logic lock_reg, tc_neg_reg, tc_pend_reg;
  logic [23:0] sens_mem [MAX_PTS];
  logic [23:0] kel_mem [MAX_PTS];
  logic [MAX_PTS-1:0] pt_valid_reg;
  logic [7:0] name_mem [NAME_LEN];
  logic [7:0] serial_mem [SERIAL_LEN];
  logic pready_reg, pslverr_reg;
  logic [31:0] prdata_reg, rd_data;
  logic bad;

  // Keys are asynchronous pins: two flops before any use
  logic [3:0] key_meta, key_sync, key_last;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_meta <= 4'h0;
      key_sync <= 4'h0;
      key_last <= 4'h0;
    end else begin
      key_meta <= {key_select, key_enter, key_up, key_down};
      key_sync <= key_meta;
      key_last <= key_sync;
    end
  end
  wire sel_k = key_sync[3];
  wire ent_k = key_sync[2];
  wire ud_k = key_sync[1] & key_sync[0];
  wire sel_edge = sel_k & ~key_last[3];

  // Hold timers; a fired flag keeps one action per press
  logic [31:0] ent_cnt_reg, ud_cnt_reg;
  logic ent_fired_reg, ud_fired_reg;
  wire ent_fire = ent_k & ~ent_fired_reg &
                  (ent_cnt_reg == 32'(HOLD_CYCLES - 1));
  wire ud_fire = ud_k & ~lock_reg & ~ud_fired_reg &
                 (ud_cnt_reg == 32'(HOLD_CYCLES - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ent_cnt_reg <= 32'h0;
      ent_fired_reg <= 1'b0;
    end else if (!ent_k) begin
      ent_cnt_reg <= 32'h0;
      ent_fired_reg <= 1'b0;
    end else if (ent_fire) begin
      ent_fired_reg <= 1'b1;
    end else if (!ent_fired_reg) begin
      ent_cnt_reg <= ent_cnt_reg + 32'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ud_cnt_reg <= 32'h0;
      ud_fired_reg <= 1'b0;
    end else if (!ud_k || lock_reg) begin
      ud_cnt_reg <= 32'h0;
      ud_fired_reg <= 1'b0;
    end else if (ud_fire) begin
      ud_fired_reg <= 1'b1;
    end else if (!ud_fired_reg) begin
      ud_cnt_reg <= ud_cnt_reg + 32'h1;
    end
  end

  // APB decode
  wire setup = psel & ~penable;
  wire access = psel & penable & pready_reg;
  wire wr_ok = access & pwrite & ~pslverr_reg;
  wire is_user = curve_sel_reg == USER_CURVE;
  wire [11:0] name_ofs = paddr - OFS_NAME;
  wire [11:0] ser_ofs = paddr - OFS_SERIAL;
  wire in_name = paddr >= OFS_NAME && name_ofs[11:2] < 10'(NAME_LEN) &&
                 paddr[1:0] == 2'h0;
  wire in_ser = paddr >= OFS_SERIAL && ser_ofs[11:2] < 10'(SERIAL_LEN) &&
                paddr[1:0] == 2'h0;
  wire [7:0] wch = pwdata[7:0];
  wire alnum = (wch >= 8'h30 && wch <= 8'h39) ||
               (wch >= 8'h41 && wch <= 8'h5a) ||
               (wch >= 8'h61 && wch <= 8'h7a);

  logic err_reg, conv_busy;
  logic [23:0] temp_reg;
  logic [15:0] level_reg;
  logic cur_reg;
  always_comb begin
    rd_data = 32'h0;
    bad = 1'b0;
    case (paddr)
      OFS_CTRL: rd_data = 32'(ctrl_reg);
      OFS_ALARM_HI: rd_data = 32'(alarm_hi_reg);
      OFS_ALARM_LO: rd_data = 32'(alarm_lo_reg);
      OFS_DEADBAND: rd_data = 32'(deadband_reg);
      OFS_STATUS: begin
        rd_data = {28'h0, conv_busy, tc_neg_reg, err_reg, lock_reg};
        bad = pwrite;
      end
      OFS_TEMP: begin
        rd_data = 32'(temp_reg);
        bad = pwrite;
      end
      OFS_OUTPUT: begin
        rd_data = {15'h0, cur_reg, level_reg};
        bad = pwrite;
      end
      OFS_CURVE_SEL: begin
        rd_data = 32'(curve_sel_reg);
        bad = pwrite && (pwdata[4:0] == 5'h0 || pwdata[4:0] > USER_CURVE);
      end
      OFS_HDR: begin
        if (is_user) rd_data = {29'h0, tc_neg_reg, fmt_reg};
        bad = pwrite && (!is_user || pwdata[1:0] > FMT_LOGOHM);
      end
      OFS_LIMIT: begin
        if (is_user) rd_data = 32'(limit_reg);
        bad = pwrite && !is_user;
      end
      OFS_PT_IDX: begin
        rd_data = 32'(pt_idx_reg);
        bad = pwrite && pwdata[31:0] >= 32'(MAX_PTS);
      end
      OFS_PT_SENS: begin
        if (is_user) rd_data = 32'(sens_mem[pt_idx_reg]);
        bad = pwrite && !is_user;
      end
      OFS_PT_KELV: begin
        if (is_user) rd_data = 32'(kel_mem[pt_idx_reg]);
        bad = pwrite && !is_user;
      end
      OFS_CMD: ;
      default: begin
        if (in_name) begin
          if (is_user) rd_data = 32'(name_mem[name_ofs[5:2]]);
          bad = pwrite && !is_user;
        end else if (in_ser) begin
          if (is_user) rd_data = 32'(serial_mem[ser_ofs[5:2]]);
          bad = pwrite && (!is_user || !alnum);
        end else begin
          bad = 1'b1;
        end
      end
    endcase
  end

  // Answer in the access cycle that follows setup: no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else if (setup) begin
      pready_reg <= 1'b1;
      pslverr_reg <= bad;
      prdata_reg <= pwrite ? 32'h0 : rd_data;
    end else if (access) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // Nonvolatile parameters; restore never touches curve storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_DEFAULT;
      alarm_hi_reg <= 16'h0;
      alarm_lo_reg <= 16'h0;
      deadband_reg <= 16'h0;
      curve_sel_reg <= DEFAULT_CURVE;
    end else if (ud_fire) begin
      ctrl_reg <= CTRL_DEFAULT;
      alarm_hi_reg <= 16'h0;
      alarm_lo_reg <= 16'h0;
      deadband_reg <= 16'h0;
      curve_sel_reg <= DEFAULT_CURVE;
    end else if (wr_ok) begin
      case (paddr)
        OFS_CTRL: begin
          ctrl_reg <= pwdata[CTRL_W-1:0];
          if (pwdata[RANGE_LSB+:3] > RANGE_MAX)
            ctrl_reg[RANGE_LSB+:3] <= RANGE_MAX;
        end
        OFS_ALARM_HI: alarm_hi_reg <= pwdata[15:0];
        OFS_ALARM_LO: alarm_lo_reg <= pwdata[15:0];
        OFS_DEADBAND: deadband_reg <= pwdata[15:0];
        OFS_CURVE_SEL: curve_sel_reg <= pwdata[4:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lock_reg <= 1'b0;
    else if (ud_fire) lock_reg <= 1'b0;
    else if (ent_fire) lock_reg <= ~lock_reg;
  end

  // User curve header and points, reachable only from the bus
  function automatic logic [23:0] quant_k(input logic [31:0] v);
    logic [31:0] c;
    c = (v > K_SPAN) ? K_SPAN : v;
    if (c >= K_COARSE) quant_k = 24'(c - c % K_STEP_COARSE);
    else if (c >= K_FINE_TOP) quant_k = 24'(c - c % K_STEP_MID);
    else quant_k = c[23:0];
  endfunction : quant_k

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt_reg <= FMT_VOLT;
      limit_reg <= LIMIT_DEFAULT;
      pt_idx_reg <= 8'h0;
      pt_valid_reg <= '0;
    end else if (wr_ok) begin
      case (paddr)
        OFS_HDR: fmt_reg <= pwdata[1:0];
        OFS_LIMIT: limit_reg <= pwdata[15:0];
        OFS_PT_IDX: pt_idx_reg <= pwdata[7:0];
        OFS_PT_KELV: pt_valid_reg[pt_idx_reg] <= pwdata != 32'h0;
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk) begin
    if (wr_ok && paddr == OFS_PT_SENS) sens_mem[pt_idx_reg] <= pwdata[23:0];
    if (wr_ok && paddr == OFS_PT_KELV)
      kel_mem[pt_idx_reg] <= quant_k(pwdata);
    if (wr_ok && in_name) name_mem[name_ofs[5:2]] <= wch;
    if (wr_ok && in_ser) serial_mem[ser_ofs[5:2]] <= wch;
  end

  // Coefficient sign: ignores host value, set once per reset or command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tc_pend_reg <= 1'b1;
      tc_neg_reg <= 1'b0;
    end else if (wr_ok && paddr == OFS_CMD && pwdata[0]) begin
      tc_pend_reg <= 1'b1;
    end else if (tc_pend_reg) begin
      tc_pend_reg <= 1'b0;
      if (pt_valid_reg[1])
        tc_neg_reg <= (sens_mem[1] > sens_mem[0]) !=
                      (kel_mem[1] > kel_mem[0]);
    end
  end

  // Conversion: search, interpolate, scale; one shared serial divider
  conv_type state_reg;
  logic [7:0] idx_reg;
  logic [23:0] x_reg, k0_reg, den_reg;
  logic [47:0] quo_reg, quo_nx;
  logic [24:0] rem_reg, rem_sh, rem_nx;
  logic [5:0] cnt_reg;
  logic neg_reg, done_reg, mode_reg;
  always_comb begin
    rem_sh = {rem_reg[23:0], quo_reg[47]};
    if (rem_sh >= {1'b0, den_reg}) begin
      rem_nx = rem_sh - {1'b0, den_reg};
      quo_nx = {quo_reg[46:0], 1'b1};
    end else begin
      rem_nx = rem_sh;
      quo_nx = {quo_reg[46:0], 1'b0};
    end
  end
  wire [7:0] nxt = idx_reg + 8'h1;
  wire [23:0] s0 = sens_mem[idx_reg];
  wire [23:0] k0 = kel_mem[idx_reg];
  wire [23:0] top = range_top(ctrl_reg[RANGE_LSB+:3]);
  wire [23:0] t_new = neg_reg ? k0_reg - quo_nx[23:0]
                              : k0_reg + quo_nx[23:0];
  wire [23:0] t_clip = (t_new > top) ? top : t_new;
  wire cur_mode = ctrl_reg[MODE_BIT];
  assign conv_busy = state_reg != CV_IDLE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= CV_IDLE;
      idx_reg <= 8'h0;
      x_reg <= 24'h0;
      k0_reg <= 24'h0;
      den_reg <= 24'h1;
      quo_reg <= 48'h0;
      rem_reg <= 25'h0;
      cnt_reg <= 6'h0;
      neg_reg <= 1'b0;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      temp_reg <= 24'h0;
      level_reg <= 16'h0;
      cur_reg <= 1'b0;
      mode_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      unique case (state_reg)
        CV_IDLE: begin
          x_reg <= sensor_value;
          idx_reg <= 8'h0;
          state_reg <= CV_SEARCH;
        end
        CV_SEARCH: begin
          if (!is_user || !pt_valid_reg[0] || x_reg < sens_mem[0] ||
              nxt == 8'(MAX_PTS)) begin
            err_reg <= 1'b1;
            state_reg <= CV_IDLE;
          end else if (!pt_valid_reg[nxt]) begin
            err_reg <= 1'b1;
            state_reg <= CV_IDLE;
          end else if (x_reg <= sens_mem[nxt]) begin
            neg_reg <= kel_mem[nxt] < k0;
            k0_reg <= k0;
            den_reg <= (sens_mem[nxt] == s0) ? 24'h1 : sens_mem[nxt] - s0;
            quo_reg <= (x_reg - s0) * ((kel_mem[nxt] < k0) ?
                       k0 - kel_mem[nxt] : kel_mem[nxt] - k0);
            rem_reg <= 25'h0;
            cnt_reg <= 6'(DIV_STEPS - 1);
            state_reg <= CV_DIV_T;
          end else begin
            idx_reg <= nxt;
          end
        end
        CV_DIV_T: begin
          quo_reg <= quo_nx;
          rem_reg <= rem_nx;
          cnt_reg <= cnt_reg - 6'h1;
          if (cnt_reg == 6'h0) begin
            temp_reg <= t_new;
            quo_reg <= t_clip * (cur_mode ? I_SPAN_UA : V_FULL_MV);
            den_reg <= top;
            rem_reg <= 25'h0;
            cnt_reg <= 6'(DIV_STEPS - 1);
            mode_reg <= cur_mode;
            state_reg <= CV_DIV_O;
          end
        end
        CV_DIV_O: begin
          quo_reg <= quo_nx;
          rem_reg <= rem_nx;
          cnt_reg <= cnt_reg - 6'h1;
          if (cnt_reg == 6'h0) begin
            level_reg <= mode_reg ? I_ZERO_UA + quo_nx[15:0] : quo_nx[15:0];
            // Mode flips with its level, so the pins never mix two modes
            cur_reg <= mode_reg;
            err_reg <= 1'b0;
            done_reg <= 1'b1;
            state_reg <= CV_IDLE;
          end
        end
      endcase
    end
  end

  // Alarms with deadband; a latched alarm waits for the select key
  logic hi_act_reg, lo_act_reg;
  wire [31:0] hi_k = 32'(alarm_hi_reg) * ALARM_SCALE;
  wire [31:0] lo_k = 32'(alarm_lo_reg) * ALARM_SCALE;
  wire [31:0] db_k = 32'(deadband_reg) * ALARM_SCALE;
  wire [31:0] t32 = 32'(temp_reg);
  wire alarm_on = ctrl_reg[ALARM_ON_BIT];
  wire latch_on = ctrl_reg[LATCH_BIT];
  wire hi_set = alarm_on & done_reg & (t32 >= hi_k);
  wire lo_set = alarm_on & done_reg & (t32 <= lo_k);
  wire hi_rel = done_reg & ~latch_on & (t32 + db_k < hi_k);
  wire lo_rel = done_reg & ~latch_on & (t32 > lo_k + db_k);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_act_reg <= 1'b0;
      lo_act_reg <= 1'b0;
    end else begin
      // Set wins over a same-cycle clear
      if (hi_set) hi_act_reg <= 1'b1;
      else if (!alarm_on || hi_rel || (latch_on && sel_edge))
        hi_act_reg <= 1'b0;
      if (lo_set) lo_act_reg <= 1'b1;
      else if (!alarm_on || lo_rel || (latch_on && sel_edge))
        lo_act_reg <= 1'b0;
    end
  end

  // Display and output pins, all registered
  disp_type disp_next;
  always_comb begin
    if (ud_fired_reg) disp_next = DISP_ALL_ON;
    else if (ent_fired_reg)
      disp_next = lock_reg ? DISP_LOCKED : DISP_UNLOCKED;
    else if (sel_k && !lock_reg) disp_next = DISP_DATE;
    else if (err_reg) disp_next = DISP_ERROR;
    else disp_next = DISP_NORMAL;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_mode <= DISP_NORMAL;
      disp_value <= 24'h0;
      disp_bright <= 4'h0;
      out_current <= 1'b0;
      out_level <= 16'h0;
      relay1 <= 1'b0;
      relay2 <= 1'b0;
    end else begin
      disp_mode <= disp_next;
      disp_value <= (disp_next == DISP_DATE) ? FW_DATE : temp_reg;
      disp_bright <= ctrl_reg[BRIGHT_LSB+:4];
      out_current <= cur_reg;
      out_level <= level_reg;
      relay1 <= ctrl_reg[RLY1_LSB+:2] == RLY_ON ||
                (ctrl_reg[RLY1_LSB+:2] == RLY_ALARM && lo_act_reg);
      relay2 <= ctrl_reg[RLY2_LSB+:2] == RLY_ON ||
                (ctrl_reg[RLY2_LSB+:2] == RLY_ALARM && hi_act_reg);
    end
  end
endmodule : curve_readout

// ---- verif/curve_readout_props.sv ----
`timescale 1ns/1ps
module curve_readout_props
  import curve_pkg::*;
#(
  parameter int HOLD_CYCLES = HOLD_S * CLK_HZ,
  parameter logic [23:0] FW_DATE = 24'h010100
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic key_enter,
  input wire logic key_up,
  input wire logic key_down,
  input wire logic out_current,
  input wire logic [15:0] out_level,
  input wire logic [2:0] disp_mode,
  input wire logic [23:0] disp_value
);
  int enter_cnt;
  int both_cnt;

  // Raw pin run lengths; the design sees keys two cycles later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) enter_cnt <= 0;
    else if (!key_enter) enter_cnt <= 0;
    else if (enter_cnt < HOLD_CYCLES) enter_cnt <= enter_cnt + 1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) both_cnt <= 0;
    else if (!(key_up && key_down)) both_cnt <= 0;
    else if (both_cnt < HOLD_CYCLES) both_cnt <= both_cnt + 1;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence lock_shown;
    $rose(disp_mode inside {DISP_LOCKED, DISP_UNLOCKED});
  endsequence
  sequence restore_shown;
    $rose(disp_mode == DISP_ALL_ON);
  endsequence

  a_ready_after_setup: assert property (apb_setup |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held two cycles");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_current_span: assert property (out_current |->
    out_level >= 16'h0fa0 && out_level <= 16'h4e20)
    else $error("current level out of span");
  a_voltage_span: assert property (!out_current |->
    out_level <= 16'h2710)
    else $error("voltage level out of span");
  a_date_value: assert property (disp_mode == DISP_DATE |->
    disp_value == FW_DATE)
    else $error("date display value wrong");
  a_lock_held: assert property (lock_shown |->
    $past(enter_cnt, 3) >= HOLD_CYCLES - 4)
    else $error("lock toggled without full hold");
  a_restore_held: assert property (restore_shown |->
    $past(both_cnt, 3) >= HOLD_CYCLES - 4)
    else $error("restore without full hold");
endmodule : curve_readout_props

bind curve_readout curve_readout_props #(
  .HOLD_CYCLES(HOLD_CYCLES),
  .FW_DATE(FW_DATE)
) props (.*);

// ---- verif/key_panel.sv ----
`timescale 1ns/1ps
module key_panel (
  input wire logic pclk,
  output logic key_select,
  output logic key_enter,
  output logic key_up,
  output logic key_down
);
  initial {key_select, key_enter, key_up, key_down} = 4'h0;

  // Keys move only after an edge so the pin synchroniser never races
  task automatic set(input logic [3:0] k);
    @(posedge pclk);
    {key_select, key_enter, key_up, key_down} <= k;
  endtask : set
endmodule : key_panel

// ---- verif/temp_curve_lookup_front_panel_tb.sv ----
`timescale 1ns/1ps
module temp_curve_lookup_front_panel_tb;
  import curve_pkg::*;
  localparam int HOLD = 20;
  localparam logic [23:0] DATE = 24'h123456; // Arbitrary value
  localparam logic [31:0] ALL = 32'hffffffff;
  logic pclk = 1'b0, presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic [23:0] sensor_value = 24'h0, disp_value;
  logic pready, pslverr, out_current, relay1, relay2, md;
  logic key_select, key_enter, key_up, key_down;
  logic [15:0] out_level;
  logic [2:0] disp_mode, rg;
  logic [3:0] disp_bright;
  logic [31:0] kq[4] = '{32'hbc614e, 32'h1e240, 32'hd431, 32'h1312d00};
  logic [31:0] kx[4] = '{32'hbc6100, 32'h1e23a, 32'hd431, 32'he4e1c0};
  logic [31:0] ps[5] = '{32'h3e8, 32'h7d0, 32'hbb8, 32'h0, 32'hfa0};
  logic [31:0] pk[5] = '{32'h2dc6c0, 32'h1e8480, 32'h16e360, 32'h0,
                         32'hf4240};
  int num_errors = 0, samples_checked = 0, s, e;

  always #50 pclk = ~pclk;

  curve_readout #(.HOLD_CYCLES(HOLD), .FW_DATE(DATE)) dut (.*);
  key_panel pnl (.*);

  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (!ok) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask : chk

  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic acc(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (pready !== 1'b1) begin
      chk(1'b0, "apb timeout");
      give_verdict();
    end
    rdv = prdata;
    chk(pslverr === err, "pslverr");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : acc

  task automatic rd(input logic [11:0] a, input logic [31:0] mk,
                    input logic [31:0] ex);
    acc(1'b0, a, 32'h0, 1'b0);
    chk((rdv & mk) === ex, "read value");
  endtask : rd

  task automatic press(input logic [3:0] k, input disp_type m);
    pnl.set(k);
    repeat (HOLD + 8) @(posedge pclk);
    @(negedge pclk);
    chk(disp_mode === m, "display while held");
    if (m == DISP_DATE) chk(disp_value === DATE, "date");
    pnl.set(4'h0);
    repeat (8) @(posedge pclk);
    @(negedge pclk);
    chk(m == DISP_NORMAL || disp_mode !== m, "display after release");
  endtask : press

  function automatic int kel(input int v);
    return v <= 2000 ? 4000000 - 1000 * v : 3000000 - 500 * v;
  endfunction : kel

  function automatic int lvl(input int t, input logic [2:0] r,
                             input logic m);
    longint top[6] = '{200000, 1000000, 2000000, 3250000, 4750000,
                       10000000};
    if (m) return int'(4000 + longint'(t) * 16000 / top[r]);
    return int'(longint'(t) * 10000 / top[r]);
  endfunction : lvl

  initial begin
    repeat (100000) @(posedge pclk);
    chk(1'b0, "run timeout");
    give_verdict();
  end

  initial begin
    void'($urandom(32'hc713760e));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_CTRL, ALL, 32'h8a);
    rd(OFS_CURVE_SEL, ALL, 32'h1);
    acc(1'b1, OFS_PT_SENS, 32'h1, 1'b1);
    acc(1'b1, OFS_TEMP, 32'h1, 1'b1);
    acc(1'b1, 12'h3fc, 32'h1, 1'b1);
    acc(1'b1, OFS_CURVE_SEL, 32'h16, 1'b1);
    acc(1'b1, OFS_CURVE_SEL, 32'h15, 1'b0);
    rd(OFS_LIMIT, 32'hffff, 32'h177);
    acc(1'b1, OFS_HDR, 32'h3, 1'b1);
    acc(1'b1, OFS_HDR, 32'h2, 1'b0);
    acc(1'b1, OFS_NAME + 12'h03c, 32'h41, 1'b1);
    acc(1'b1, OFS_SERIAL, 32'h21, 1'b1);
    acc(1'b1, OFS_PT_IDX, 32'hc8, 1'b1);
    acc(1'b1, OFS_PT_IDX, 32'hc7, 1'b0);
    foreach (kq[i]) begin
      acc(1'b1, OFS_PT_KELV, kq[i], 1'b0);
      rd(OFS_PT_KELV, ALL, kx[i]);
    end
    acc(1'b1, OFS_PT_KELV, 32'h0, 1'b0);
    for (int i = 0; i < 5; i++) begin
      acc(1'b1, OFS_PT_IDX, 32'(i), 1'b0);
      acc(1'b1, OFS_PT_SENS, ps[i], 1'b0);
      acc(1'b1, OFS_PT_KELV, pk[i], 1'b0);
    end
    acc(1'b1, OFS_CMD, 32'h1, 1'b0);
    rd(OFS_STATUS, 32'h4, 32'h4);
    acc(1'b1, OFS_PT_IDX, 32'h1, 1'b0);
    acc(1'b1, OFS_PT_KELV, 32'h3d0900, 1'b0);
    rd(OFS_STATUS, 32'h4, 32'h4);
    acc(1'b1, OFS_CMD, 32'h1, 1'b0);
    rd(OFS_HDR, 32'h4, 32'h0);
    acc(1'b1, OFS_PT_KELV, 32'h1e8480, 1'b0);
    acc(1'b1, OFS_CMD, 32'h1, 1'b0);
    repeat (6) begin
      s = 1000 + $urandom_range(2000);
      rg = 3'(3 + $urandom_range(2));
      md = 1'($urandom_range(1));
      sensor_value <= 24'(s);
      acc(1'b1, OFS_CTRL, {13'h0, 15'h8, rg, md}, 1'b0);
      repeat (250) @(posedge pclk);
      e = kel(s);
      rd(OFS_TEMP, ALL, 32'(e));
      e = lvl(e, rg, md);
      @(negedge pclk);
      chk(out_current === md, "output mode");
      chk(out_level === 16'(e) || out_level === 16'(e + 1) ||
          out_level === 16'(e - 1), "output level");
    end
    // Past the blank location; the point behind it must be ignored
    sensor_value <= 24'hdac;
    repeat (250) @(posedge pclk);
    rd(OFS_STATUS, 32'h2, 32'h2);
    @(negedge pclk);
    chk(disp_mode === DISP_ERROR, "error display");
    sensor_value <= 24'h5dc;
    repeat (250) @(posedge pclk);
    press(4'h8, DISP_DATE);
    repeat (2) begin
      pnl.set(4'h4);
      repeat (HOLD - 6) @(posedge pclk);
      pnl.set(4'h0);
      repeat (3) @(posedge pclk);
    end
    rd(OFS_STATUS, 32'h1, 32'h0);
    press(4'h4, DISP_LOCKED);
    rd(OFS_STATUS, 32'h1, 32'h1);
    press(4'h3, DISP_NORMAL);
    press(4'h8, DISP_NORMAL);
    press(4'h4, DISP_UNLOCKED);
    acc(1'b1, OFS_CTRL, 32'h1, 1'b0);
    press(4'h3, DISP_ALL_ON);
    rd(OFS_CTRL, ALL, 32'h8a);
    acc(1'b1, OFS_CURVE_SEL, 32'h15, 1'b0);
    rd(OFS_PT_KELV, ALL, 32'h1e8480);
    // Low alarm at 300 K against 250 K, latched; relay 1 follows it
    acc(1'b1, OFS_ALARM_LO, 32'hbb8, 1'b0);
    acc(1'b1, OFS_CTRL, 32'h3608a, 1'b0);
    repeat (250) @(posedge pclk);
    acc(1'b1, OFS_ALARM_LO, 32'h0, 1'b0);
    repeat (250) @(posedge pclk);
    @(negedge pclk);
    chk(relay1 === 1'b1 && relay2 === 1'b1, "relays set");
    chk(disp_bright === 4'h8, "brightness");
    press(4'h4, DISP_LOCKED);
    press(4'h8, DISP_NORMAL);
    chk(relay1 === 1'b0, "latched alarm not cleared");
    give_verdict();
  end
endmodule : temp_curve_lookup_front_panel_tb
